// ===== core/bmch_map.svh
// Purpose: Register map, field positions and timing figures of the bridge misc control
// Assumes: 32-bit register bus, byte addresses, one aligned word per register
// Notes: Definitions only
`ifndef BMCH_MAP_SVH
`define BMCH_MAP_SVH

`define BMCH_ADDR_W 8
`define BMCH_DATA_W 32
`define BMCH_REG_CTRL 8'h00
`define BMCH_REG_CLKCTRL 8'h04
`define BMCH_REG_GPIO_OE 8'h08
`define BMCH_REG_GPIO_OUT 8'h0c
`define BMCH_REG_GPIO_IN 8'h10
`define BMCH_REG_HSCSR 8'h14
`define BMCH_REG_STRAP 8'h18
`define BMCH_REG_INT_STAT 8'h1c
`define BMCH_REG_INT_MASK 8'h20

`define BMCH_PS_W 2
`define BMCH_PS_D3HOT 2'h3
`define BMCH_PS_RESET 2'h0
`define BMCH_GPIO_W 4
`define BMCH_GPIO_EJECT 3
`define BMCH_HS_IND_BIT 0
`define BMCH_HS_EJECT_BIT 1
`define BMCH_HS_EN_BIT 2
`define BMCH_HS_W 3

`define BMCH_EV_EJECT 0
`define BMCH_EV_MASKED 1
`define BMCH_EV_SRST 2
`define BMCH_EV_W 3

`define BMCH_NUM_SEC_CLOCKS 10
`define BMCH_SRST_DELAY_US 100
`define BMCH_CLOCK_MHZ 100

`endif

// ===== core/bmch_pkg.sv
// Purpose: Types shared by the bridge misc control
// Assumes: Widths from bmch_map.svh
// Notes: Pin group is synchronised as one vector
`include "bmch_map.svh"
package bmch_pkg;

  typedef enum logic [1:0] {
    ST_SHIFT,
    ST_WAIT,
    ST_RUN
  } bmch_state_e;

  typedef struct packed {
    logic maskSerial;
    logic fastStrap;
    logic primarySpeed;
    logic secSpeed;
    logic busPowerStrap;
    logic modeLow;
    logic modeHigh;
    logic [`BMCH_GPIO_W-1:0] gpioIn;
  } bmch_pins_s;

  typedef struct packed {
    logic b2Active;
    logic halfRate;
    bmch_pins_s pins;
  } bmch_strap_s;

endpackage

// ===== core/bmch_ctrl.sv
// Purpose: Secondary clock mask, speed straps, D3hot clock gating, GPIO and hot-swap logic
// Assumes: Pins asynchronous to clock; register master on clock, never waits
// Notes: Clock outputs are enables and idle levels for an external clock tree
`include "bmch_map.svh"

// Behaviour
// - After reset release, shift mask serial input in to choose disabled clocks.
// - Each shifted high bit disables its clock; bits land in clock control register.
// - Secondary reset released 100 us after masked clocks are disabled.
// - Mask input low keeps all clocks running; high holds all clocks high.
// - Fast-capable strap high reports 66 MHz capability, low limits to 33.
// - Primary speed select high means 66 MHz primary, low means 33.
// - Secondary speed is wired-OR; secondary 66 MHz only while it is high.
// - Primary speed low: drive secondary speed low during reset.
// - Strap high and D3hot: secondary bus to B2, all clocks stopped low.
// - Strap low: D3hot leaves secondary clocks running unchanged.
// - Hot-swap mode: GPIO 3 is the active-low ejector switch input.
// - Hot-swap enabled and ejector event: notify output driven low.
// - Indicator output follows software indicator bit: 0 off, 1 on.
// - Mode low 0 and mode high 1: hot-swap on, GPIO 3 is ejector.
// - Mode low 1: hot-swap off, GPIO 3 ordinary GPIO.
// - Ten secondary clock outputs derived from primary clock, mask-selected.
// - Half rate when secondary speed low and primary high, else full rate.
module bmch_ctrl
  import bmch_pkg::*;
#(
  parameter int NumSecClocks = `BMCH_NUM_SEC_CLOCKS,
  parameter int SrstDelayCycles = `BMCH_SRST_DELAY_US * `BMCH_CLOCK_MHZ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register bus
  input wire logic [`BMCH_ADDR_W-1:0] regAddr,
  input wire logic [`BMCH_DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`BMCH_DATA_W-1:0] regReadData,
  // Straps and mode pins
  input wire logic clockMaskSerialIn,
  input wire logic fastCapableStrap,
  input wire logic primarySpeedSelect,
  input wire logic busPowerClockStrap,
  input wire logic modeSelectLow,
  input wire logic modeSelectHigh,
  // Secondary speed open-drain pin
  input wire logic secondarySpeedWiredOrIn,
  output logic secondarySpeedWiredOrOut,
  output logic secondarySpeedWiredOrOeN,
  // Secondary clocks and reset
  output logic [NumSecClocks-1:0] secClockEnable,
  output logic secClockIdleLevel,
  output logic secClockHalfRate,
  output logic secResetN,
  // Speed reports
  output logic fastCapable,
  output logic primaryFast,
  output logic secondaryFast,
  // GPIO pins, bit 3 doubles as ejector switch
  input wire logic [`BMCH_GPIO_W-1:0] gpioIn,
  output logic [`BMCH_GPIO_W-1:0] gpioOut,
  output logic [`BMCH_GPIO_W-1:0] gpioOeN,
  // Hot-swap and interrupt
  output logic hotswapNotifyN,
  output logic hotswapIndicator,
  output logic irq
);

  localparam int PinW = $bits(bmch_pins_s);
  localparam int CountW = $clog2(SrstDelayCycles + 1);
  localparam int ShiftW = $clog2(NumSecClocks + 1);
  localparam logic [CountW-1:0] DelayLast = CountW'(SrstDelayCycles - 1);
  localparam logic [ShiftW-1:0] ShiftLast = ShiftW'(NumSecClocks - 1);

  if (NumSecClocks < 1 || NumSecClocks > `BMCH_DATA_W) begin : gBadClocks
    $error("NumSecClocks must be 1 to data width");
  end
  if (SrstDelayCycles < 1) begin : gBadDelay
    $error("SrstDelayCycles must be at least 1");
  end

  // Pin synchronisers
  // No reset: the flops fill while reset is held
  bmch_pins_s pinsRaw;
  bmch_pins_s pins;
  logic [PinW-1:0] syncFirst;
  logic [PinW-1:0] syncSecond;

  assign pinsRaw.maskSerial = clockMaskSerialIn;
  assign pinsRaw.fastStrap = fastCapableStrap;
  assign pinsRaw.primarySpeed = primarySpeedSelect;
  assign pinsRaw.secSpeed = secondarySpeedWiredOrIn;
  assign pinsRaw.busPowerStrap = busPowerClockStrap;
  assign pinsRaw.modeLow = modeSelectLow;
  assign pinsRaw.modeHigh = modeSelectHigh;
  assign pinsRaw.gpioIn = gpioIn;

  always_ff @(posedge clock) begin
    syncFirst <= pinsRaw;
    syncSecond <= syncFirst;
  end
  assign pins = syncSecond;

  // State
  bmch_state_e state;
  bmch_state_e next_state;
  logic [ShiftW-1:0] shiftCount;
  logic [CountW-1:0] delayCount;
  logic [NumSecClocks-1:0] clockDisable;
  logic [`BMCH_PS_W-1:0] powerState;
  logic [`BMCH_GPIO_W-1:0] gpioOe;
  logic [`BMCH_GPIO_W-1:0] gpioData;
  logic indicatorBit;
  logic ejectorPrev;
  logic [`BMCH_EV_W-1:0] intStatus;
  logic [`BMCH_EV_W-1:0] intMask;

  // Register decode
  wire wrCtrl = regWrite && regAddr == `BMCH_REG_CTRL;
  wire wrClk = regWrite && regAddr == `BMCH_REG_CLKCTRL;
  wire wrOe = regWrite && regAddr == `BMCH_REG_GPIO_OE;
  wire wrOut = regWrite && regAddr == `BMCH_REG_GPIO_OUT;
  wire wrHs = regWrite && regAddr == `BMCH_REG_HSCSR;
  wire wrStat = regWrite && regAddr == `BMCH_REG_INT_STAT;
  wire wrMask = regWrite && regAddr == `BMCH_REG_INT_MASK;

  // Mode decode
  // Hot-swap enable decode
  wire hsEnabled = !pins.modeLow && pins.modeHigh;
  wire ejectorSwitchN = pins.gpioIn[`BMCH_GPIO_EJECT];
  wire ejectorEvent = hsEnabled && (ejectorSwitchN != ejectorPrev);

  // Power and speed decode
  // B2 under D3hot
  wire b2Active = pins.busPowerStrap && powerState == `BMCH_PS_D3HOT;
  wire halfRate = !pins.secSpeed && pins.primarySpeed;

  // Reset sequence
  // Mask shift, then reset wait, then run
  wire shiftDone = state == ST_SHIFT && shiftCount == ShiftLast;
  wire delayDone = state == ST_WAIT && delayCount == DelayLast;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_SHIFT: if (shiftDone) begin
        next_state = ST_WAIT;
      end
      ST_WAIT: if (delayDone) begin
        next_state = ST_RUN;
      end
      ST_RUN: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ST_SHIFT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || state != ST_SHIFT) begin
      shiftCount <= '0;
    end else begin
      shiftCount <= shiftCount + ShiftW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || state != ST_WAIT) begin
      delayCount <= '0;
    end else begin
      delayCount <= delayCount + CountW'(1);
    end
  end

  // Clock control register
  logic [NumSecClocks-1:0] next_clockDisable;
  always_comb begin
    next_clockDisable = clockDisable;
    // Shift owns the register; writes meanwhile are lost
    // Shifted bit per clock
    if (state == ST_SHIFT) begin
      next_clockDisable[shiftCount] = pins.maskSerial;
    end else if (wrClk) begin
      next_clockDisable = regWriteData[NumSecClocks-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      clockDisable <= '0;
    end else begin
      clockDisable <= next_clockDisable;
    end
  end

  // Control registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      powerState <= `BMCH_PS_RESET;
      intMask <= '0;
      indicatorBit <= 1'b0;
    end else begin
      if (wrCtrl) begin
        powerState <= regWriteData[`BMCH_PS_W-1:0];
      end
      if (wrMask) begin
        intMask <= regWriteData[`BMCH_EV_W-1:0];
      end
      if (wrHs) begin
        indicatorBit <= regWriteData[`BMCH_HS_IND_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gpioOe <= '0;
      gpioData <= '0;
    end else begin
      if (wrOe) begin
        gpioOe <= regWriteData[`BMCH_GPIO_W-1:0];
      end
      if (wrOut) begin
        gpioData <= regWriteData[`BMCH_GPIO_W-1:0];
      end
    end
  end

  // Interrupt events, set beats clear
  logic [`BMCH_EV_W-1:0] eventSet;
  logic [`BMCH_EV_W-1:0] eventClear;
  always_comb begin
    eventSet = '0;
    eventSet[`BMCH_EV_EJECT] = ejectorEvent;
    eventSet[`BMCH_EV_MASKED] = shiftDone;
    eventSet[`BMCH_EV_SRST] = delayDone;
    eventClear = wrStat ? regWriteData[`BMCH_EV_W-1:0] : '0;
  end

  // Switch idles high, so no false edge after reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      intStatus <= '0;
      ejectorPrev <= 1'b1;
    end else begin
      intStatus <= (intStatus & ~eventClear) | eventSet;
      ejectorPrev <= ejectorSwitchN;
    end
  end

  wire [`BMCH_EV_W-1:0] next_intStatus = (intStatus & ~eventClear) | eventSet;

  // Read mux
  bmch_strap_s strapView;
  assign strapView.b2Active = b2Active;
  assign strapView.halfRate = halfRate;
  assign strapView.pins = pins;

  wire [`BMCH_HS_W-1:0] hsView;
  assign hsView[`BMCH_HS_IND_BIT] = indicatorBit;
  assign hsView[`BMCH_HS_EJECT_BIT] = ejectorSwitchN;
  assign hsView[`BMCH_HS_EN_BIT] = hsEnabled;
  // Unmapped addresses read as zero
  wire [`BMCH_DATA_W-1:0] readMux =
    regAddr == `BMCH_REG_CTRL ? `BMCH_DATA_W'(powerState) :
    regAddr == `BMCH_REG_CLKCTRL ? `BMCH_DATA_W'(clockDisable) :
    regAddr == `BMCH_REG_GPIO_OE ? `BMCH_DATA_W'(gpioOe) :
    regAddr == `BMCH_REG_GPIO_OUT ? `BMCH_DATA_W'(gpioData) :
    regAddr == `BMCH_REG_GPIO_IN ? `BMCH_DATA_W'(pins.gpioIn) :
    regAddr == `BMCH_REG_HSCSR ? `BMCH_DATA_W'(hsView) :
    regAddr == `BMCH_REG_STRAP ? `BMCH_DATA_W'(strapView) :
    regAddr == `BMCH_REG_INT_STAT ? `BMCH_DATA_W'(intStatus) :
    regAddr == `BMCH_REG_INT_MASK ? `BMCH_DATA_W'(intMask) :
    '0;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      regReadData <= '0;
    end else begin
      // Zero outside the answer cycle of a read
      regReadData <= regRead ? readMux : '0;
    end
  end

  // Secondary clock outputs
  // Per-clock enable
  wire [NumSecClocks-1:0] next_secClockEnable =
    b2Active ? '0 : ~next_clockDisable;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      secClockEnable <= '0;
      secClockIdleLevel <= 1'b1;
      secClockHalfRate <= 1'b0;
    end else begin
      secClockEnable <= next_secClockEnable;
      secClockIdleLevel <= !b2Active;
      secClockHalfRate <= halfRate;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      secResetN <= 1'b0;
    end else begin
      // Rises on the last wait edge, no extra lag
      secResetN <= next_state == ST_RUN;
    end
  end

  // Speed reports
  // Pull secondary speed low
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      secondarySpeedWiredOrOut <= 1'b0;
      secondarySpeedWiredOrOeN <= 1'b0;
      fastCapable <= 1'b0;
      primaryFast <= 1'b0;
      secondaryFast <= 1'b0;
    end else begin
      secondarySpeedWiredOrOut <= 1'b0;
      // Open drain: only ever pulls the line low
      secondarySpeedWiredOrOeN <= pins.primarySpeed || next_state == ST_RUN;
      fastCapable <= pins.fastStrap;
      primaryFast <= pins.primarySpeed;
      secondaryFast <= pins.secSpeed;
    end
  end

  // GPIO pins and hot-swap outputs
  // Ejector pin stays input-only in hot-swap mode
  wire [`BMCH_GPIO_W-1:0] ejectorKeep =
    hsEnabled ? `BMCH_GPIO_W'(1) << `BMCH_GPIO_EJECT : '0;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gpioOut <= '0;
      gpioOeN <= '1;
      hotswapNotifyN <= 1'b1;
      hotswapIndicator <= 1'b0;
      irq <= 1'b0;
    end else begin
      gpioOut <= gpioData;
      gpioOeN <= ~(gpioOe & ~ejectorKeep);
      hotswapNotifyN <= !(hsEnabled && next_intStatus[`BMCH_EV_EJECT]);
      hotswapIndicator <= wrHs ? regWriteData[`BMCH_HS_IND_BIT] : indicatorBit;
      // Next value, so irq rises with its status bit
      irq <= |(next_intStatus & intMask);
    end
  end

endmodule

// ===== tb/bmch_checker.sv
// Purpose: Port checks for the bridge misc control
// Assumes: Pins held steady for a few cycles around each change
// Notes: Pin-fed outputs lag their pins by three cycles
module bmch_checker #(
  parameter int NumSecClocks = 10,
  parameter int SrstDelayCycles = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Straps and mode pins
  input wire logic fastCapableStrap,
  input wire logic modeSelectLow,
  input wire logic modeSelectHigh,
  // Outputs watched
  input wire logic secondarySpeedWiredOrOut,
  input wire logic secondarySpeedWiredOrOeN,
  input wire logic [NumSecClocks-1:0] secClockEnable,
  input wire logic secClockIdleLevel,
  input wire logic secResetN,
  input wire logic fastCapable,
  input wire logic [3:0] gpioOeN,
  input wire logic hotswapNotifyN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] upCount;
  wire hsMode = !modeSelectLow && modeSelectHigh;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Cycles since reset release
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      upCount <= 16'h0;
    end else if (upCount != 16'hffff) begin
      upCount <= upCount + 16'h1;
    end
  end
  sequence steady(p);
    upCount > 16'h5 && p == $past(p, 1) && p == $past(p, 2) && p == $past(p, 3);
  endsequence
  reset_a: assert property (disable iff (1'b0)
    !reset_n |=> !secResetN && gpioOeN == 4'hf) else $error("reset state wrong");
  pull_a: assert property (disable iff (1'b0)
    !reset_n |=> !secondarySpeedWiredOrOeN && !secondarySpeedWiredOrOut)
    else $error("speed line not pulled in reset");
  drop_a: assert property (!secondarySpeedWiredOrOeN |-> !$past(secResetN))
    else $error("speed line pulled after reset");
  srst_a: assert property ($rose(secResetN) |->
    upCount == 16'(NumSecClocks + SrstDelayCycles))
    else $error("secondary reset released at wrong time");
  fast_a: assert property (steady(fastCapableStrap) |-> fastCapable == fastCapableStrap)
    else $error("fast capable report wrong");
  b2_a: assert property (!secClockIdleLevel |-> secClockEnable == '0)
    else $error("clock running while parked low");
  hsgpio_a: assert property (steady(hsMode) ##0 hsMode |-> gpioOeN[3])
    else $error("switch pin driven in hot-swap mode");
  notify_a: assert property ($fell(hotswapNotifyN) |-> hsMode)
    else $error("notify without hot-swap mode");
endmodule

// ===== tb/bmch_board.sv
// Purpose: Board side: secondary devices on the speed line, GPIO pins
// Assumes: Speed line has a pull-up; a slow device pulls it low
// Notes: Undriven GPIO pins show the board level
module bmch_board (
  // Bridge side
  input wire logic secondarySpeedWiredOrOut,
  input wire logic secondarySpeedWiredOrOeN,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] gpioOeN,
  // Board side
  input wire logic devicesFast,
  input wire logic [3:0] boardPins,
  output logic secondarySpeedWiredOrIn,
  output logic [3:0] gpioIn
);
  timeunit 1ns;
  timeprecision 1ps;
  assign secondarySpeedWiredOrIn = devicesFast && (secondarySpeedWiredOrOeN
    || secondarySpeedWiredOrOut);
  assign gpioIn = (gpioOut & ~gpioOeN) | (boardPins & gpioOeN);
endmodule

// ===== tb/bmch_ctrl_tb.sv
// Purpose: Self-checking bench for the bridge misc control
// Assumes: Secondary reset wait shortened to 20 cycles
// Notes: Board model drives speed line and GPIO pins
module bmch_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] want;
  } bmch_row_s;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWriteData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic clockMaskSerialIn = 1'b1;
  logic fastCapableStrap = 1'b0;
  logic primarySpeedSelect = 1'b0;
  logic busPowerClockStrap = 1'b0;
  logic modeSelectLow = 1'b1;
  logic modeSelectHigh = 1'b0;
  logic devicesFast = 1'b1;
  logic [3:0] boardPins = 4'ha;
  logic [31:0] regReadData;
  logic [9:0] secClockEnable;
  logic [3:0] gpioIn, gpioOut, gpioOeN;
  logic secondarySpeedWiredOrIn, secondarySpeedWiredOrOut, secondarySpeedWiredOrOeN;
  logic secClockIdleLevel, secClockHalfRate, secResetN, fastCapable, primaryFast;
  logic secondaryFast, hotswapNotifyN, hotswapIndicator, irq;
  int fails = 0;
  int nCompared = 0;
  int i;
  bmch_row_s rows [9] = '{
    '{8'h08, 32'h5, 32'h5}, '{8'h0c, 32'h3, 32'h3}, '{8'h10, 32'hff, 32'hb},
    '{8'h14, 32'h1, 32'h3}, '{8'h24, 32'hffffffff, 32'h0}, '{8'h1c, 32'h7, 32'h0},
    '{8'h20, 32'h7, 32'h7}, '{8'h04, 32'h155, 32'h155}, '{8'h00, 32'h3, 32'h3}};
  always #5 clock = ~clock;
  bmch_ctrl #(.SrstDelayCycles(20)) bmch_ctrl_i (
    .clock(clock),
    .reset_n(reset_n),
    .regAddr(regAddr),
    .regWriteData(regWriteData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regReadData(regReadData),
    .clockMaskSerialIn(clockMaskSerialIn),
    .fastCapableStrap(fastCapableStrap),
    .primarySpeedSelect(primarySpeedSelect),
    .busPowerClockStrap(busPowerClockStrap),
    .modeSelectLow(modeSelectLow),
    .modeSelectHigh(modeSelectHigh),
    .secondarySpeedWiredOrIn(secondarySpeedWiredOrIn),
    .secondarySpeedWiredOrOut(secondarySpeedWiredOrOut),
    .secondarySpeedWiredOrOeN(secondarySpeedWiredOrOeN),
    .secClockEnable(secClockEnable),
    .secClockIdleLevel(secClockIdleLevel),
    .secClockHalfRate(secClockHalfRate),
    .secResetN(secResetN),
    .fastCapable(fastCapable),
    .primaryFast(primaryFast),
    .secondaryFast(secondaryFast),
    .gpioIn(gpioIn),
    .gpioOut(gpioOut),
    .gpioOeN(gpioOeN),
    .hotswapNotifyN(hotswapNotifyN),
    .hotswapIndicator(hotswapIndicator),
    .irq(irq)
  );
  bmch_board bmch_board_i (
    .secondarySpeedWiredOrOut(secondarySpeedWiredOrOut),
    .secondarySpeedWiredOrOeN(secondarySpeedWiredOrOeN),
    .gpioOut(gpioOut),
    .gpioOeN(gpioOeN),
    .devicesFast(devicesFast),
    .boardPins(boardPins),
    .secondarySpeedWiredOrIn(secondarySpeedWiredOrIn),
    .gpioIn(gpioIn)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nCompared++;
    if (seen !== want) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    check(regReadData, want);
  endtask
  task automatic do_reset(input logic m);
    @(posedge clock);
    reset_n <= 1'b0;
    clockMaskSerialIn <= m;
    primarySpeedSelect <= 1'b0;
    settle(20);
    check(secResetN, 1'b0);
    check(secondarySpeedWiredOrIn, 1'b0);
    check(gpioOeN, 4'hf);
    @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i < 100 && secResetN !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check(i, 32'd30);
    check(secResetN, 1'b1);
  endtask
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    test_done;
  end
  initial begin
    do_reset(1'b1);
    check(secClockEnable, 10'h0);
    check(secClockIdleLevel, 1'b1);
    rd(8'h04, 32'h3ff);
    rd(8'h1c, 32'h6);
    do_reset(1'b0);
    check(secClockEnable, 10'h3ff);
    rd(8'h04, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 9; r++) begin
      wr(rows[r].addr, rows[r].data);
      rd(rows[r].addr, rows[r].want);
    end
    check(gpioOeN, 4'ha);
    check(hotswapIndicator, 1'b1);
    settle(3);
    check(secClockEnable, 10'h2aa);
    @(posedge clock);
    busPowerClockStrap <= 1'b1;
    settle(6);
    check(secClockEnable, 10'h0);
    check(secClockIdleLevel, 1'b0);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h0);
    settle(3);
    check(secClockEnable, 10'h2aa);
    check(hotswapIndicator, 1'b0);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      fastCapableStrap <= i[0];
      primarySpeedSelect <= i[1];
      devicesFast <= i[2];
      settle(5);
      check(fastCapable, i[0]);
      check(primaryFast, i[1]);
      check(secondaryFast, i[2]);
      check(secClockHalfRate, i[1] & !i[2]);
    end
    $display("test speed done");
    @(posedge clock);
    modeSelectLow <= 1'b0;
    modeSelectHigh <= 1'b1;
    settle(5);
    wr(8'h08, 32'hf);
    settle(3);
    check(gpioOeN, 4'h8);
    rd(8'h14, 32'h6);
    @(posedge clock);
    boardPins <= 4'h2;
    settle(6);
    check(hotswapNotifyN, 1'b0);
    check(irq, 1'b1);
    rd(8'h1c, 32'h1);
    wr(8'h1c, 32'h1);
    settle(2);
    check(irq, 1'b0);
    check(hotswapNotifyN, 1'b1);
    wr(8'h20, 32'h0);
    @(posedge clock);
    boardPins <= 4'ha;
    settle(6);
    check(irq, 1'b0);
    check(hotswapNotifyN, 1'b0);
    wr(8'h1c, 32'h1);
    @(posedge clock);
    modeSelectLow <= 1'b1;
    settle(6);
    rd(8'h10, 32'h3);
    check(hotswapNotifyN, 1'b1);
    @(posedge clock);
    modeSelectLow <= 1'b0;
    modeSelectHigh <= 1'b0;
    settle(6);
    rd(8'h14, 32'h0);
    $display("test hot-swap done");
    test_done;
  end
endmodule

bind bmch_ctrl bmch_checker #(
  .NumSecClocks(NumSecClocks),
  .SrstDelayCycles(SrstDelayCycles)
) bmch_checker_i (
  .clock(clock),
  .reset_n(reset_n),
  .fastCapableStrap(fastCapableStrap),
  .modeSelectLow(modeSelectLow),
  .modeSelectHigh(modeSelectHigh),
  .secondarySpeedWiredOrOut(secondarySpeedWiredOrOut),
  .secondarySpeedWiredOrOeN(secondarySpeedWiredOrOeN),
  .secClockEnable(secClockEnable),
  .secClockIdleLevel(secClockIdleLevel),
  .secResetN(secResetN),
  .fastCapable(fastCapable),
  .gpioOeN(gpioOeN),
  .hotswapNotifyN(hotswapNotifyN)
);
